// File: mceb_pkg.sv
// Purpose: shared constants and carrier types for the machine error bank block
// Assumes: one core clock, software access through a plain model-register port
// Notes:   bank register addresses follow the first bank at a fixed base
package mceb_pkg;
  localparam logic [7:0]  MCEB_EXC_VECTOR      = 8'h12;      // exception vector 18
  localparam logic [31:0] MCEB_BANK_BASE       = 32'h0000_0400;
  localparam logic [31:0] MCEB_CAP_ADDR        = 32'h0000_0179;
  localparam logic [31:0] MCEB_GSTAT_ADDR      = 32'h0000_017A;
  localparam logic [31:0] MCEB_LEGACY_ADDR_REG = 32'h0000_0000;
  localparam logic [31:0] MCEB_LEGACY_TYPE_REG = 32'h0000_0001;
  localparam int          MCEB_REGS_PER_BANK   = 4;          // ctl, status, addr, misc
  localparam logic [1:0]  MCEB_OFS_STATUS      = 2'h1;
  localparam logic [1:0]  MCEB_OFS_ADDR        = 2'h2;
  localparam logic [1:0]  MCEB_OFS_MISC        = 2'h3;
  // bank status field positions
  localparam int          MCEB_ST_VALID        = 63;
  localparam int          MCEB_ST_OVER         = 62;
  localparam int          MCEB_ST_UNCORR       = 61;
  localparam int          MCEB_ST_EN           = 60;
  localparam int          MCEB_ST_MISC_OK      = 59;
  localparam int          MCEB_ST_ADDR_OK      = 58;
  localparam int          MCEB_ST_CTX          = 57;
  // global status and capability field positions
  localparam int          MCEB_GS_RESTART      = 0;
  localparam int          MCEB_GS_POINTER      = 1;
  localparam int          MCEB_GS_IN_PROG      = 2;
  localparam int          MCEB_CAP_RECOV       = 24;
  localparam logic [63:0] MCEB_RESET_VALUE     = 64'h0000_0000_0000_0000;

  // one detected error as the detectors present it
  typedef struct packed {
    logic        uncorrected;
    logic        context_corrupt;
    logic        restart_ok;
    logic        pointer_related;
    logic        addr_ok;
    logic        misc_ok;
    logic [15:0] code;
    logic [63:0] addr;
    logic [63:0] misc;
  } mceb_err_type;
endpackage : mceb_pkg

// File: mceb_bank_if.sv
// Purpose: carrier between the top block and each error bank
// Assumes: one core clock
// Notes:   log strobe, software write and bank state travel together
`timescale 1ns/1ns
`default_nettype none
interface mceb_bank_if;
  import mceb_pkg::*;
  logic         log_stb;     // detector logs an error into this bank
  mceb_err_type err;
  logic         clr_stb;     // software writes the status register
  logic [63:0]  clr_data;
  logic [63:0]  status;
  logic [63:0]  addr;
  logic [63:0]  misc;
  modport top  (output log_stb, err, clr_stb, clr_data, input status, addr, misc);
  modport bank (input log_stb, err, clr_stb, clr_data, output status, addr, misc);
endinterface : mceb_bank_if
`default_nettype wire

// File: mceb_bank.sv
// Purpose: one error-reporting bank with status, address and misc registers
// Assumes: software write and a new error may land in the same cycle
// Notes:   a new error beats a software clear so nothing is lost
`timescale 1ns/1ns
`default_nettype none
module mceb_bank
  import mceb_pkg::*;
(
  input  wire logic  mclk_in,
  input  wire logic  reset_in,
  input  wire logic  clk_en_in,
  mceb_bank_if.bank  bus
);
  logic [63:0] status_q;
  logic [63:0] status_d;
  logic [63:0] addr_q;
  logic [63:0] misc_q;
  logic [63:0] logged;

  // fresh status word built from the detector report
  assign logged = {1'b1, status_q[MCEB_ST_VALID], bus.err.uncorrected, 1'b1,
                   bus.err.misc_ok, bus.err.addr_ok, bus.err.context_corrupt,
                   41'h0, bus.err.code};
  // a second error on a full bank marks overflow and context corrupt and keeps the first
  assign status_d = bus.log_stb ? (status_q[MCEB_ST_VALID] ?
                      (status_q | 64'h4200_0000_0000_0000) : logged) :
                    bus.clr_stb ? bus.clr_data : status_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      status_q <= MCEB_RESET_VALUE;
      addr_q   <= MCEB_RESET_VALUE;
      misc_q   <= MCEB_RESET_VALUE;
    end else if (clk_en_in) begin
      status_q <= status_d;
      if (bus.log_stb && !status_q[MCEB_ST_VALID]) begin
        addr_q <= bus.err.addr;
        misc_q <= bus.err.misc;
      end
    end
  end

  assign bus.status = status_q;
  assign bus.addr   = addr_q;
  assign bus.misc   = misc_q;

  // overflow must always carry the unrecoverable mark
  over_ctx_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    clk_en_in && bus.log_stb && status_q[MCEB_ST_VALID]
    |=> status_q[MCEB_ST_OVER] && status_q[MCEB_ST_CTX])
    else $error("overflow without context corrupt");
  clear_valid_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    clk_en_in && bus.clr_stb && !bus.log_stb && bus.clr_data == 64'h0
    |=> !status_q[MCEB_ST_VALID] && !status_q[MCEB_ST_OVER])
    else $error("bank clear left valid or overflow");
  relog_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    clk_en_in && bus.log_stb && !status_q[MCEB_ST_VALID]
    |=> status_q[MCEB_ST_VALID] && status_q[MCEB_ST_UNCORR] == $past(bus.err.uncorrected))
    else $error("cleared bank did not take new error");
endmodule : mceb_bank
`default_nettype wire

// File: mceb_top.sv
// Purpose: machine error banks, global status, capability and exception raise
// Assumes: detectors give one error per cycle with a bank index
// Notes:   model registers are read and written through a plain port
//
// Operation
// - exception delivered on vector eighteen
// - bank zero starts at address 400H
// - capability count reports implemented banks
// - valid set only when bank logged; a software write to the bank status register can also set it
// - hardware corrects; uncorrected flag shows outcome
// - corrected errors logged, no exception
// - context corrupt or overflow marks unrecoverable
// - restart valid only if resume reliable
// - pointer valid when pushed pointer relates
// - in-progress set on every exception
// - uncorrected error while in progress means shutdown
// - writing zeros clears overflow and valid
// - cleared bank accepts next error
// - address and misc valid flags set
// - legacy registers may read invalid
// - capability bit 24 shows recoverable support
`timescale 1ns/1ns
`default_nettype none
module mceb_top
  import mceb_pkg::*;
#(
  parameter int         NUM_BANKS     = 4,
  parameter logic       RECOV_SUPPORT = 1'b0
) (
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        clk_en_in,
  input  wire logic        err_valid_in,
  input  wire logic [7:0]  err_bank_in,
  input  wire logic        err_uncorrected_in,
  input  wire logic        err_context_corrupt_in,
  input  wire logic        err_restart_ok_in,
  input  wire logic        err_pointer_related_in,
  input  wire logic        err_addr_ok_in,
  input  wire logic        err_misc_ok_in,
  input  wire logic [15:0] err_code_in,
  input  wire logic [63:0] err_addr_in,
  input  wire logic [63:0] err_misc_in,
  input  wire logic        msr_rd_in,
  input  wire logic        msr_wr_in,
  input  wire logic [31:0] msr_addr_in,
  input  wire logic [63:0] msr_wdata_in,
  output logic      [63:0] msr_rdata_out,
  output logic             msr_hit_out,
  output logic             machine_error_exception_out,
  output logic      [7:0]  exception_vector_out,
  output logic             shutdown_out,
  output logic             restart_valid_flag_out,
  output logic             error_pointer_valid_flag_out,
  output logic             exception_in_progress_flag_out
);
  mceb_bank_if bank_bus [NUM_BANKS] ();

  logic         restart_q;
  logic         pointer_q;
  logic         in_prog_q;
  logic         shut_q;
  logic         exc_q;
  logic [63:0]  rdata_q;
  logic         hit_q;
  logic         raise;
  logic         recurse;
  logic         gstat_wr;
  logic         bank_space;
  logic [31:0]  bank_rel;
  logic [7:0]   sel_bank;
  logic [1:0]   sel_reg;
  logic [63:0]  cap_word;
  logic [63:0]  gstat_word;
  logic [63:0]  bank_rd [NUM_BANKS];

  // address decode of the whole bank window; four registers per bank
  function automatic logic bank_hit(input logic [31:0] a, input int nb);
    logic [31:0] span;
    span = 32'(nb * MCEB_REGS_PER_BANK);
    return (a >= MCEB_BANK_BASE) && (a < MCEB_BANK_BASE + span);
  endfunction : bank_hit

  // only uncorrected errors raise the exception; corrected ones just log
  assign raise    = err_valid_in && err_uncorrected_in && !shut_q;
  assign recurse  = raise && in_prog_q;
  assign gstat_wr = msr_wr_in && (msr_addr_in == MCEB_GSTAT_ADDR);

  // bank window decode
  assign bank_space = bank_hit(msr_addr_in, NUM_BANKS);
  assign bank_rel   = msr_addr_in - MCEB_BANK_BASE;
  assign sel_bank   = bank_rel[9:2];
  assign sel_reg    = bank_rel[1:0];

  // capability: bank count low byte, recoverable support at bit 24
  assign cap_word = {39'h0, RECOV_SUPPORT, 16'h0, 8'(NUM_BANKS)};
  assign gstat_word = {61'h0, in_prog_q, pointer_q, restart_q};

  // per-bank wiring of detector strobes and software writes
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
      assign bank_bus[gi].log_stb = err_valid_in && (err_bank_in == 8'(gi));
      assign bank_bus[gi].err = '{err_uncorrected_in, err_context_corrupt_in,
                                  err_restart_ok_in, err_pointer_related_in,
                                  err_addr_ok_in, err_misc_ok_in, err_code_in,
                                  err_addr_in, err_misc_in};
      assign bank_bus[gi].clr_stb  = msr_wr_in && bank_space &&
                                     (sel_bank == 8'(gi)) && (sel_reg == MCEB_OFS_STATUS);
      assign bank_bus[gi].clr_data = msr_wdata_in;
      assign bank_rd[gi] = (sel_reg == MCEB_OFS_STATUS) ? bank_bus[gi].status :
                           (sel_reg == MCEB_OFS_ADDR)   ? bank_bus[gi].addr   :
                           (sel_reg == MCEB_OFS_MISC)   ? bank_bus[gi].misc   : 64'h0;
      mceb_bank u_bank (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .clk_en_in (clk_en_in),
        .bus       (bank_bus[gi])
      );
    end
  endgenerate

  // global status: hardware set wins over a software write in one cycle
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      restart_q <= 1'b0;
      pointer_q <= 1'b0;
      in_prog_q <= 1'b0;
      shut_q    <= 1'b0;
      exc_q     <= 1'b0;
    end else if (clk_en_in) begin
      exc_q <= raise && !in_prog_q;
      if (recurse) begin
        shut_q <= 1'b1;
      end
      if (raise && !in_prog_q) begin
        in_prog_q <= 1'b1;
        restart_q <= err_restart_ok_in && !err_context_corrupt_in;
        pointer_q <= err_pointer_related_in;
      end else if (gstat_wr) begin
        in_prog_q <= msr_wdata_in[MCEB_GS_IN_PROG];
        restart_q <= msr_wdata_in[MCEB_GS_RESTART];
        pointer_q <= msr_wdata_in[MCEB_GS_POINTER];
      end
    end
  end

  // register read port; legacy registers answer zero, their data is not valid
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rdata_q <= MCEB_RESET_VALUE;
      hit_q   <= 1'b0;
    end else if (clk_en_in) begin
      hit_q <= msr_rd_in;
      if (!msr_rd_in) begin
        rdata_q <= MCEB_RESET_VALUE;
      end else if (msr_addr_in == MCEB_CAP_ADDR) begin
        rdata_q <= cap_word;
      end else if (msr_addr_in == MCEB_GSTAT_ADDR) begin
        rdata_q <= gstat_word;
      end else if (bank_space && sel_bank < 8'(NUM_BANKS)) begin
        rdata_q <= bank_rd[sel_bank[$clog2(NUM_BANKS)-1:0]];
      end else begin
        rdata_q <= MCEB_RESET_VALUE;
      end
    end
  end

  assign msr_rdata_out                  = rdata_q;
  assign msr_hit_out                    = hit_q;
  assign machine_error_exception_out    = exc_q;
  assign exception_vector_out           = MCEB_EXC_VECTOR;
  assign shutdown_out                   = shut_q;
  assign restart_valid_flag_out         = restart_q;
  assign error_pointer_valid_flag_out   = pointer_q;
  assign exception_in_progress_flag_out = in_prog_q;

  sequence first_raise_s;
    clk_en_in && raise && !in_prog_q;
  endsequence

  exc_in_prog_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    first_raise_s |=> machine_error_exception_out && in_prog_q)
    else $error("exception without in-progress flag");
  corrected_quiet_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    clk_en_in && err_valid_in && !err_uncorrected_in
    |=> !machine_error_exception_out)
    else $error("corrected error raised exception");
  recursion_shut_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    clk_en_in && recurse |=> shutdown_out && !machine_error_exception_out)
    else $error("recursion did not shut down");
  restart_cause_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    first_raise_s |=> restart_q == $past(err_restart_ok_in && !err_context_corrupt_in))
    else $error("restart flag wrong");
  pointer_cause_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    first_raise_s |=> pointer_q == $past(err_pointer_related_in))
    else $error("pointer flag wrong");
  // the pulse must never leave without the in-progress mark beside it
  vector_fixed_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    machine_error_exception_out
    |-> exception_vector_out == 8'h12 && exception_in_progress_flag_out)
    else $error("wrong exception vector or no in-progress flag");
  cap_count_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    clk_en_in && msr_rd_in && msr_addr_in == MCEB_CAP_ADDR
    |=> msr_rdata_out[7:0] == 8'(NUM_BANKS) && msr_rdata_out[24] == RECOV_SUPPORT)
    else $error("capability word wrong");
endmodule : mceb_top
`default_nettype wire

// File: test_machine_error_banks.sv
// Purpose: self-checking bench for the machine error bank block
// Assumes: four banks, recoverable support strapped on, clock enable dropped once at the end
// Notes:   the enable bit of a bank status is masked, its setting is left to the design
`timescale 1ns/1ns
`default_nettype none
module test_machine_error_banks;
  import mceb_pkg::*;
  localparam logic [63:0] ALL   = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] SMASK = 64'hEFFF_FFFF_FFFF_FFFF;  // ignore enable bit
  logic        mclk_in, reset_in, clk_en_in, err_valid_in;
  logic [7:0]  err_bank_in;
  logic [5:0]  qual;                    // uncorrected, ctx, restart, pointer, addr ok, misc ok
  logic [15:0] err_code_in;
  logic [63:0] err_addr_in, err_misc_in, msr_wdata_in, msr_rdata_out;
  logic        msr_rd_in, msr_wr_in, msr_hit_out, exc_out, shutdown_out;
  logic        rst_flag, ptr_flag, ip_flag;
  logic [31:0] msr_addr_in;
  logic [7:0]  exception_vector_out;
  int          err_count, checks_done;

  mceb_top #(.NUM_BANKS(4), .RECOV_SUPPORT(1'b1)) mceb_top_inst (
    .mclk_in(mclk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .err_valid_in(err_valid_in), .err_bank_in(err_bank_in),
    .err_uncorrected_in(qual[5]), .err_context_corrupt_in(qual[4]),
    .err_restart_ok_in(qual[3]), .err_pointer_related_in(qual[2]),
    .err_addr_ok_in(qual[1]), .err_misc_ok_in(qual[0]),
    .err_code_in(err_code_in), .err_addr_in(err_addr_in), .err_misc_in(err_misc_in),
    .msr_rd_in(msr_rd_in), .msr_wr_in(msr_wr_in), .msr_addr_in(msr_addr_in),
    .msr_wdata_in(msr_wdata_in), .msr_rdata_out(msr_rdata_out), .msr_hit_out(msr_hit_out),
    .machine_error_exception_out(exc_out), .exception_vector_out(exception_vector_out),
    .shutdown_out(shutdown_out), .restart_valid_flag_out(rst_flag),
    .error_pointer_valid_flag_out(ptr_flag), .exception_in_progress_flag_out(ip_flag));

  // free-running core clock, 8 ns period
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  task automatic chk_word(input logic [63:0] got, exp, mask, input string what);
    checks_done++;
    if ((got & mask) !== (exp & mask)) begin
      err_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  function automatic logic [31:0] ra(input int b, input logic [1:0] ofs);
    ra = MCEB_BANK_BASE + 32'(b * MCEB_REGS_PER_BANK) + 32'(ofs);
  endfunction : ra

  function automatic logic [63:0] st(input logic v, o, u, m, a, p, input logic [15:0] c);
    st = '0;
    st[MCEB_ST_VALID] = v;
    st[MCEB_ST_OVER]  = o;
    st[MCEB_ST_UNCORR]  = u;
    st[MCEB_ST_MISC_OK] = m;
    st[MCEB_ST_ADDR_OK] = a;
    st[MCEB_ST_CTX]     = p;
    st[15:0]          = c;
  endfunction : st

  // one-cycle read strobe; data and hit are looked at in the answer cycle only
  task automatic rd(input logic [31:0] addr, input logic [63:0] exp, mask);
    @(posedge mclk_in) #1;
    msr_rd_in   = 1'b1;
    msr_addr_in = addr;
    @(posedge mclk_in) #1;
    msr_rd_in = 1'b0;
    chk_bit(msr_hit_out, 1'b1, "read hit");
    chk_word(msr_rdata_out, exp, mask, "read data");
  endtask : rd

  task automatic wr(input logic [31:0] addr, input logic [63:0] data);
    @(posedge mclk_in) #1;
    msr_wr_in    = 1'b1;
    msr_addr_in  = addr;
    msr_wdata_in = data;
    @(posedge mclk_in) #1;
    msr_wr_in = 1'b0;
  endtask : wr

  // address and misc data derive from the code so every bank logs distinct words
  task automatic inject(input int b, input logic [5:0] q, input logic [15:0] c, input logic exc);
    @(posedge mclk_in) #1;
    err_valid_in = 1'b1;
    err_bank_in  = 8'(b);
    qual         = q;
    err_code_in  = c;
    err_addr_in  = {48'h1234_5678_9ABC, c};
    err_misc_in  = ~{48'h1234_5678_9ABC, c};
    @(posedge mclk_in) #1;
    err_valid_in = 1'b0;
    chk_bit(exc_out, exc, "exception pulse");
  endtask : inject

  task automatic flags(input logic [3:0] f);  // shutdown, in progress, pointer, restart
    chk_bit(shutdown_out, f[3], "shutdown");
    chk_bit(ip_flag, f[2], "in progress");
    chk_bit(ptr_flag, f[1], "pointer valid");
    chk_bit(rst_flag, f[0], "restart valid");
  endtask : flags

  task automatic finish_test();
    $display("checks_done %0d err_count %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // watchdog: the sequence needs well under 300 cycles
  initial begin
    repeat (3000) @(posedge mclk_in);
    err_count++;
    finish_test();
  end

  // main sequence
  initial begin
    {reset_in, clk_en_in} = 2'b11;
    {err_valid_in, msr_rd_in, msr_wr_in} = 3'b000;
    {err_bank_in, qual, err_code_in} = '0;
    {err_addr_in, err_misc_in, msr_wdata_in, msr_addr_in} = '0;
    err_count   = 0;
    checks_done = 0;
    repeat (2) @(posedge mclk_in);
    #1 reset_in = 1'b0;
    flags(4'b0000);
    chk_word(64'(exception_vector_out), 64'(MCEB_EXC_VECTOR), ALL, "vector");
    rd(MCEB_CAP_ADDR, 64'h0000_0000_0100_0004, ALL);
    rd(MCEB_GSTAT_ADDR, '0, ALL);
    for (int b = 0; b < 4; b++) rd(ra(b, MCEB_OFS_STATUS), '0, ALL);
    rd(MCEB_LEGACY_TYPE_REG, '0, ALL);
    rd(MCEB_LEGACY_ADDR_REG, '0, ALL);
    rd(32'h0000_0410, '0, ALL);
    // corrected errors are logged quietly, with and without address and misc
    inject(1, 6'b000011, 16'h00A5, 1'b0);
    flags(4'b0000);
    rd(ra(1, MCEB_OFS_STATUS), st(1, 0, 0, 1, 1, 0, 16'h00A5), SMASK);
    rd(ra(1, MCEB_OFS_ADDR), {48'h1234_5678_9ABC, 16'h00A5}, ALL);
    rd(ra(1, MCEB_OFS_MISC), ~{48'h1234_5678_9ABC, 16'h00A5}, ALL);
    rd(MCEB_GSTAT_ADDR, '0, ALL);
    wr(ra(1, MCEB_OFS_STATUS), '0);
    rd(ra(1, MCEB_OFS_STATUS), '0, ALL);
    inject(2, 6'b000000, 16'h0011, 1'b0);
    rd(ra(2, MCEB_OFS_STATUS), st(1, 0, 0, 0, 0, 0, 16'h0011), SMASK);
    // uncorrected error raises the exception and the global flags
    inject(0, 6'b101100, 16'h0150, 1'b1);
    flags(4'b0111);
    rd(MCEB_GSTAT_ADDR, 64'h0000_0000_0000_0007, ALL);
    rd(ra(0, MCEB_OFS_STATUS), st(1, 0, 1, 0, 0, 0, 16'h0150), SMASK);
    // second error into a full bank overflows and keeps the first data
    inject(0, 6'b000011, 16'h0222, 1'b0);
    flags(4'b0111);
    rd(ra(0, MCEB_OFS_STATUS), st(1, 1, 1, 0, 0, 1, 16'h0150), SMASK);
    rd(ra(0, MCEB_OFS_STATUS), 64'h0000_0000_0000_0150, 64'h0000_0000_0000_FFFF);
    wr(ra(0, MCEB_OFS_STATUS), '0);
    rd(ra(0, MCEB_OFS_STATUS), '0, ALL);
    inject(0, 6'b000011, 16'h0033, 1'b0);
    rd(ra(0, MCEB_OFS_STATUS), st(1, 0, 0, 1, 1, 0, 16'h0033), SMASK);
    wr(MCEB_GSTAT_ADDR, '0);
    chk_bit(ip_flag, 1'b0, "in progress cleared");
    // not restartable, pointer unrelated
    inject(3, 6'b100000, 16'h0044, 1'b1);
    flags(4'b0100);
    // recursion: uncorrected error while in progress
    inject(2, 6'b100000, 16'h0055, 1'b0);
    chk_bit(shutdown_out, 1'b1, "shutdown on recursion");
    inject(1, 6'b101100, 16'h0066, 1'b0);
    chk_bit(shutdown_out, 1'b1, "shutdown sticky");
    // clock enable low: software writes must not land anywhere
    clk_en_in = 1'b0;
    wr(MCEB_GSTAT_ADDR, '0);
    wr(ra(0, MCEB_OFS_STATUS), '0);
    clk_en_in = 1'b1;
    chk_bit(ip_flag, 1'b1, "in progress frozen");
    rd(ra(0, MCEB_OFS_STATUS), st(1, 0, 0, 1, 1, 0, 16'h0033), SMASK);
    finish_test();
  end
endmodule : test_machine_error_banks
`default_nettype wire
